// [mdspi_host_model.sv]
// Host serial master model for the motor driver port
`timescale 1ns/1ps
`default_nettype none
module mdspi_host_model (
  output logic frame_select_n, // Select to device
  output logic sclk, // Serial clock
  output logic sdi, // Data to device
  input wire logic sdo, // Data from device
  input wire logic sdo_oe_n // Low while device drives
);
  logic last_bit;
  logic oe_seen;
  wire logic miso;
  // Released line shows the inverse of its last value
  assign miso = sdo_oe_n ? ~last_bit : sdo;
  initial begin
    frame_select_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    last_bit = 1'b0;
    oe_seen = 1'b1;
  end
  // ------------------------------------------------------------
  // Frame of nbits, sent from tx[nbits-1] down
  // ------------------------------------------------------------
  task automatic frame(input int nbits, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0000_0000;
    frame_select_n = 1'b0;
    #40;
    for (int i = nbits - 1; i >= 0; i--) begin
      sclk = 1'b1;
      sdi = tx[i];
      #40;
      if (i == nbits - 1) oe_seen = sdo_oe_n;
      rx[i] = miso;
      last_bit = miso;
      sclk = 1'b0;
      #40;
    end
    sdi = ~sdi;
    frame_select_n = 1'b1;
    #600;
  endtask
  // Clock and data activity while deselected
  task automatic noise();
    for (int i = 0; i < 16; i++) begin
      sclk = ~sclk;
      sdi = ~sdi;
      #40;
    end
  endtask
endmodule
`default_nettype wire

// [mdspi_pkg.sv]
// Constants and types of the motor driver serial port
package mdspi_pkg;
  // ------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------
  localparam logic [4:0] ADDR_FAULT = 5'h00;
  localparam logic [4:0] ADDR_DIAG = 5'h01;
  localparam logic [4:0] ADDR_CFG1 = 5'h02;
  localparam logic [4:0] ADDR_PROT = 5'h03;
  localparam logic [4:0] ADDR_OUTC = 5'h04;
  localparam logic [4:0] ADDR_LDIAG = 5'h05;
  // ------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------
  localparam logic [7:0] RST_CFG1 = 8'h51;
  localparam logic [7:0] RST_PROT = 8'h0C;
  localparam logic [7:0] RST_OUTC = 8'h00;
  localparam logic [7:0] RST_LDIAG = 8'h00;
  localparam logic [5:0] RST_FLAGS = 6'h00;
  localparam logic [7:0] RST_DIAG = 8'h00;
  // ------------------------------------------------------------
  // Field positions and marks
  // ------------------------------------------------------------
  localparam int RW_BIT = 6;
  localparam int ADDR_HI = 5;
  localparam int ADDR_LO = 1;
  localparam int CLR_BIT = 7;
  localparam int HEADER_BYTE_SECOND_CLR = 5;
  localparam logic [1:0] MARK_STATUS = 2'h3;
  localparam logic [1:0] MARK_HDR = 2'h2;
  // ------------------------------------------------------------
  // Frame sizes
  // ------------------------------------------------------------
  localparam logic [10:0] WORD_BITS = 11'h010;
  localparam int WORD_SHIFT = 4;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // ------------------------------------------------------------
  // Byte role within a frame
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_FIRST = 3'b000,
    PH_SINGLE = 3'b001,
    PH_STATUS = 3'b010,
    PH_HEADER_BYTE_SECOND = 3'b011,
    PH_BODY = 3'b100
  } mdspi_phase_t;
endpackage

// [mdspi_top.sv]
// Serial slave port with daisy chain and status registers
// Operation
// - Input word: zero, read flag, address, data
// - Output word: 11, six flags, report
// - Deselected: ignore inputs, output high impedance
// - Sample on falling, launch on rising
// - Most significant bit first both ways
// - Wrong bit count: frame error, no update
// - Write returns old contents, then stores
// - Unselected device ignores shared bus traffic
// - Chain returns statuses, headers, reports
// - Six-bit chain length, up to 63
// - Header clear command clears faults at end
// - Low five bits of second header ignored
// - Status byte leads with two ones
// - Position from status bytes before header
// - Chain bytes mean as single frame
// - Status registers read only
// - Fault register layout, resets to zero
// - Read returns addressed register contents
// - Diagnostic register layout per bridge
`timescale 1ns/1ps
`default_nettype none
module mdspi_top
  import mdspi_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic reset_n, // Async reset
  input wire logic frame_select_n, // Select pin
  input wire logic sclk, // Serial clock pin
  input wire logic sdi, // Serial data in
  output logic sdo, // Serial data out
  output logic sdo_oe_n, // Low while driving
  input wire logic [5:0] fault_in, // Flag set pulses
  input wire logic [7:0] diag_in, // Bridge diag sets
  output logic fault_output_n, // Low on any fault
  output logic frame_error, // Last frame bad
  output logic [7:0] drive_config_one, // Config 0x02
  output logic [7:0] protection_config, // Config 0x03
  output logic [7:0] output_command_config, // Config 0x04
  output logic [7:0] load_diag_config // Config 0x05
);
  // ------------------------------------------------------------
  // Synchronisers and edges
  // ------------------------------------------------------------
  logic [2:0] cs_q;
  logic [2:0] ck_q;
  logic [1:0] di_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_q <= 3'h7;
      ck_q <= 3'h0;
      di_q <= 2'h0;
    end else begin
      cs_q <= {cs_q[1:0], frame_select_n};
      ck_q <= {ck_q[1:0], sclk};
      di_q <= {di_q[0], sdi};
    end
  end
  wire sel = !cs_q[1];
  wire cs_fall = cs_q[2] && !cs_q[1];
  wire frame_end = !cs_q[2] && cs_q[1];
  wire fall_e = sel && ck_q[2] && !ck_q[1];
  wire rise_e = sel && !ck_q[2] && ck_q[1];
  // ------------------------------------------------------------
  // Frame state
  // ------------------------------------------------------------
  mdspi_phase_t phase;
  logic [7:0] rx;
  logic [7:0] tx;
  logic [2:0] bit_i;
  logic [10:0] nbits;
  logic [5:0] pos;
  logic [5:0] chain_n;
  logic [6:0] jbody;
  logic [7:0] cmd;
  logic [7:0] dat;
  logic clr_req;
  logic clr_faults;
  logic [5:0] flags;
  logic [7:0] diag;
  wire [7:0] rx_next = {rx[6:0], di_q[1]};
  wire byte_done = fall_e && bit_i == LAST_BIT;
  wire is_status = rx_next[7:6] == MARK_STATUS;
  wire is_hdr = rx_next[7:6] == MARK_HDR;
  wire in_head = phase == PH_FIRST || phase == PH_STATUS;
  wire [4:0] rd_addr = rx_next[ADDR_HI:ADDR_LO];
  wire [7:0] fault_reg = {1'b0, |flags, flags};
  wire [7:0] rd_data = rd_addr == ADDR_FAULT ? fault_reg :
                       rd_addr == ADDR_DIAG ? diag :
                       rd_addr == ADDR_CFG1 ? drive_config_one :
                       rd_addr == ADDR_PROT ? protection_config :
                       rd_addr == ADDR_OUTC ? output_command_config :
                       rd_addr == ADDR_LDIAG ? load_diag_config : 8'h00;
  wire [6:0] addr_slot = 7'(chain_n) - 7'(pos) - 7'h01;
  wire [6:0] data_slot = 7'(chain_n) + addr_slot;
  wire [7:0] status_byte = {MARK_STATUS, flags};
  wire [10:0] chain_bits = (11'(chain_n) + 11'h001) << WORD_SHIFT;
  wire is_chain = phase == PH_BODY;
  wire ok = phase == PH_SINGLE ? nbits == WORD_BITS : is_chain && nbits == chain_bits;
  wire [4:0] wr_addr = cmd[ADDR_HI:ADDR_LO];
  wire do_write = frame_end && ok && !cmd[RW_BIT] && !cmd[7];
  wire wr_ok = do_write && wr_addr >= ADDR_CFG1 && wr_addr <= ADDR_LDIAG;
  // ------------------------------------------------------------
  // Receive, position and transmit
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= PH_FIRST;
      rx <= 8'h00;
      tx <= 8'h00;
      bit_i <= 3'h0;
      nbits <= 11'h000;
      pos <= 6'h00;
      chain_n <= 6'h00;
      jbody <= 7'h00;
      cmd <= 8'h80;
      dat <= 8'h00;
      clr_req <= 1'b0;
    end else if (cs_fall) begin
      phase <= PH_FIRST;
      tx <= status_byte;
      bit_i <= 3'h0;
      nbits <= 11'h000;
      pos <= 6'h00;
      jbody <= 7'h00;
      cmd <= 8'h80;
      clr_req <= 1'b0;
    end else begin
      if (rise_e) begin
        tx <= {tx[6:0], 1'b0};
      end
      if (fall_e) begin
        rx <= rx_next;
        bit_i <= bit_i + 3'h1;
        nbits <= &nbits ? nbits : nbits + 11'h001;
      end
      if (byte_done) begin
        unique case (phase)
          PH_FIRST, PH_STATUS: begin
            if (is_status) begin
              pos <= pos + 6'h01;
              phase <= PH_STATUS;
              tx <= rx_next;
            end else if (phase == PH_FIRST && !rx_next[7]) begin
              cmd <= rx_next;
              phase <= PH_SINGLE;
              tx <= rd_data;
            end else begin
              chain_n <= rx_next[5:0];
              phase <= PH_HEADER_BYTE_SECOND;
              tx <= rx_next;
            end
          end
          PH_HEADER_BYTE_SECOND: begin
            clr_req <= rx_next[HEADER_BYTE_SECOND_CLR];
            phase <= PH_BODY;
            tx <= rx_next;
          end
          PH_BODY: begin
            jbody <= jbody + 7'h01;
            if (jbody == addr_slot) begin
              cmd <= rx_next;
              tx <= rd_data;
            end else begin
              tx <= rx_next;
            end
            if (jbody == data_slot) begin
              dat <= rx_next;
            end
          end
          PH_SINGLE: begin
            dat <= rx_next;
            tx <= 8'h00;
          end
          default: begin
            phase <= PH_FIRST;
          end
        endcase
      end
    end
  end
  // ------------------------------------------------------------
  // Pins and registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sdo <= 1'b0;
      sdo_oe_n <= 1'b1;
      frame_error <= 1'b0;
      clr_faults <= 1'b0;
      drive_config_one <= RST_CFG1;
      protection_config <= RST_PROT;
      output_command_config <= RST_OUTC;
      load_diag_config <= RST_LDIAG;
    end else begin
      sdo_oe_n <= !sel;
      if (rise_e) begin
        sdo <= tx[7];
      end
      if (frame_end) begin
        frame_error <= !ok;
      end
      clr_faults <= frame_end && ok && is_chain && clr_req || wr_ok && wr_addr == ADDR_OUTC && dat[CLR_BIT];
      if (wr_ok && wr_addr == ADDR_CFG1) begin
        drive_config_one <= dat;
      end
      if (wr_ok && wr_addr == ADDR_PROT) begin
        protection_config <= dat;
      end
      if (wr_ok && wr_addr == ADDR_OUTC) begin
        output_command_config <= {1'b0, dat[6:0]};
      end
      if (wr_ok && wr_addr == ADDR_LDIAG) begin
        load_diag_config <= dat;
      end
    end
  end
  // Set wins over clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags <= RST_FLAGS;
      diag <= RST_DIAG;
      fault_output_n <= 1'b1;
    end else begin
      flags <= (clr_faults ? 6'h00 : flags) | fault_in;
      diag <= (clr_faults ? 8'h00 : diag) | diag_in;
      fault_output_n <= !(|flags);
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence good_write_s;
    frame_end && ok && !cmd[RW_BIT] && !cmd[7];
  endsequence
  hiz_deselect_a: assert property ($rose(cs_q[1]) |=> sdo_oe_n)
    else $error("sdo driven while deselected");
  launch_rise_a: assert property (!$past(rise_e) |-> $stable(sdo))
    else $error("sdo moved without rising edge");
  status_lead_a: assert property (cs_fall |=> tx == {2'b11, $past(flags)})
    else $error("status byte wrong");
  frame_err_a: assert property ($rose(frame_error) |-> $past(frame_end) && !$past(ok))
    else $error("frame error without bad frame");
  ro_status_a: assert property (frame_end && wr_addr <= ADDR_DIAG |=> $stable(drive_config_one))
    else $error("status write changed config");
  write_store_a: assert property (good_write_s ##0 wr_addr == ADDR_CFG1 |=> drive_config_one == $past(dat))
    else $error("write not stored");
  chain_clear_a: assert property (frame_end && ok && is_chain && clr_req |=> clr_faults ##1 flags == $past(fault_in))
    else $error("global clear missed");
  position_a: assert property (byte_done && in_head && is_status |=> pos == $past(pos) + 6'h01)
    else $error("position count wrong");
  msb_first_a: assert property (fall_e |=> rx == {$past(rx[6:0]), $past(di_q[1])})
    else $error("bit order wrong");
  report_a: assert property (byte_done && phase == PH_FIRST && !rx_next[7] |=> tx == $past(rd_data))
    else $error("report byte wrong");
  idle_ignore_a: assert property (cs_q[1] && cs_q[2] |=> $stable(rx) && $stable(nbits))
    else $error("activity while deselected");
  sticky_a: assert property (fault_in != 6'h00 |=> (flags & $past(fault_in)) == $past(fault_in))
    else $error("fault set lost");
endmodule
`default_nettype wire

// [mdspi_top_tb.sv]
// Self-checking bench for the motor driver serial port
`timescale 1ns/1ps
`default_nettype none
module mdspi_top_tb
  import mdspi_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] fault_in = 6'h00;
  logic [7:0] diag_in = 8'h00;
  logic [31:0] rx;
  int error_cnt = 0;
  int checks = 0;
  wire logic frame_select_n, sclk, sdi, sdo, sdo_oe_n, fault_output_n, frame_error;
  wire logic [7:0] cfg1, prot, outc, ldiag;
  always #5 clk = ~clk;
  mdspi_host_model u_host (.frame_select_n(frame_select_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
    .sdo_oe_n(sdo_oe_n));
  mdspi_top u_dut (.clk(clk), .reset_n(reset_n), .frame_select_n(frame_select_n), .sclk(sclk),
    .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .fault_in(fault_in), .diag_in(diag_in),
    .fault_output_n(fault_output_n), .frame_error(frame_error), .drive_config_one(cfg1),
    .protection_config(prot), .output_command_config(outc), .load_diag_config(ldiag));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic fail(input string what, input logic [31:0] got, input logic [31:0] exp);
    error_cnt++;
    $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) fail("flag", {31'h0, got}, {31'h0, exp});
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) fail("byte", {24'h0, got}, {24'h0, exp});
  endtask
  task automatic chk_frame(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) fail("frame", got, exp);
  endtask
  function automatic logic [15:0] wr(input logic [4:0] a, input logic [7:0] d);
    return {2'b00, a, 1'b0, d};
  endfunction
  function automatic logic [15:0] rd(input logic [4:0] a);
    return {2'b01, a, 1'b0, 8'h00};
  endfunction
  task automatic xfer(input logic [15:0] w);
    u_host.frame(16, {16'h0000, w}, rx);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk_bit(sdo_oe_n, 1'b1);
    chk_bit(fault_output_n, 1'b1);
    chk_bit(frame_error, 1'b0);
    chk_byte(cfg1, RST_CFG1);
    chk_byte(prot, RST_PROT);
    $display("test reset done");
  endtask
  task automatic t_write();
    logic [7:0] olds [4] = '{RST_CFG1, RST_PROT, RST_OUTC, RST_LDIAG};
    logic [7:0] news [4] = '{8'hAB, 8'h35, 8'h5A, 8'h66};
    for (int i = 0; i < 4; i++) begin
      xfer(wr(ADDR_CFG1 + 5'(i), news[i]));
      chk_frame(rx, {16'h0000, 8'hC0, olds[i]});
      chk_bit(u_host.oe_seen, 1'b0);
      xfer(rd(ADDR_CFG1 + 5'(i)));
      chk_frame(rx, {16'h0000, 8'hC0, news[i]});
    end
    chk_byte(cfg1, 8'hAB);
    chk_byte(prot, 8'h35);
    chk_byte(outc, 8'h5A);
    chk_byte(ldiag, 8'h66);
    $display("test write done");
  endtask
  task automatic t_readonly();
    xfer(wr(ADDR_FAULT, 8'hFF));
    xfer(wr(ADDR_DIAG, 8'hFF));
    xfer(rd(ADDR_FAULT));
    chk_byte(rx[7:0], 8'h00);
    xfer(rd(ADDR_DIAG));
    chk_byte(rx[7:0], 8'h00);
    xfer(rd(5'h1F));
    chk_byte(rx[7:0], 8'h00);
    $display("test readonly done");
  endtask
  task automatic t_frame_err();
    logic [15:0] w;
    w = wr(ADDR_PROT, 8'h99);
    u_host.frame(15, {17'h0, w[15:1]}, rx);
    chk_bit(frame_error, 1'b1);
    u_host.frame(17, {15'h0, w, 1'b0}, rx);
    chk_bit(frame_error, 1'b1);
    chk_byte(prot, 8'h35);
    u_host.noise();
    chk_byte(prot, 8'h35);
    chk_bit(sdo_oe_n, 1'b1);
    xfer(rd(ADDR_PROT));
    chk_bit(frame_error, 1'b0);
    $display("test frame error done");
  endtask
  task automatic t_fault_chain();
    @(negedge clk);
    fault_in = 6'h04;
    diag_in = 8'h80;
    @(negedge clk);
    fault_in = 6'h00;
    diag_in = 8'h00;
    repeat (4) @(negedge clk);
    chk_bit(fault_output_n, 1'b0);
    xfer(rd(ADDR_FAULT));
    chk_frame(rx, {16'h0000, 8'hC4, 8'h44});
    xfer(rd(ADDR_DIAG));
    chk_byte(rx[7:0], 8'h80);
    u_host.frame(32, {8'h81, 8'hB5, rd(ADDR_FAULT)}, rx);
    chk_frame(rx, {8'hC4, 8'h81, 8'hB5, 8'h44});
    chk_bit(fault_output_n, 1'b1);
    xfer(rd(ADDR_FAULT));
    chk_frame(rx, {16'h0000, 8'hC0, 8'h00});
    @(negedge clk);
    fault_in = 6'h01;
    @(negedge clk);
    fault_in = 6'h00;
    xfer(wr(ADDR_OUTC, 8'h80));
    chk_frame(rx, {16'h0000, 8'hC1, 8'h5A});
    chk_byte(outc, 8'h00);
    xfer(rd(ADDR_FAULT));
    chk_frame(rx, {16'h0000, 8'hC0, 8'h00});
    $display("test fault chain done");
  endtask
  initial begin
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    #3;
    t_reset();
    t_write();
    t_readonly();
    t_frame_err();
    t_fault_chain();
    end_sim();
  end
  initial begin
    #300000;
    fail("timeout", 32'h0, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
